// >>> hw/rtcc_time_of_day.v
// seconds, minutes and hours bcd counters with an axi4-lite register slave
// Function
// - seconds register holds bcd second, settable 00 to 59
// - free-running mode turns seconds into a plain 8-bit up-counter
// - bit 7 of min, hour, and of sec outside free-running mode, reads busy while counters update
// - seconds units bits 3:0 count 0-9, wrap increments tens
// - seconds tens bits 6:4 count 0-5, sixty-second cycle
// - minutes advance on seconds carry, settable 00 to 59
// - minutes units bits 3:0 count 0-9, wrap increments tens
// - minutes tens bits 6:4 count 0-5, sixty-minute cycle
// - hours advance on minutes carry
// - hours span 00-11 in 12-hour, 00-23 in 24-hour format
// - hours tens bits 5:4 hold 0 to 3; counting from an in-range hour keeps them 0 to 2
// - hours units bits 3:0 count 0-9, wrap increments tens
// - hours bit 6 reserved, reads 0
// - format bit: 0 selects 12-hour, 1 selects 24-hour
// - hours emit one carry per wrap for the weekday counter, one a day in 24-hour and two a day in 12-hour format
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "rtcc_regs.vh"
module rtcc_time_of_day #(
   parameter TICK_CYCLES = `RTCC_TICK_CYCLES
) (
   input wire mclk_i,
   input wire reset_n_i,
   input wire [3:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [3:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   output reg day_carry_o
);
   reg [3:0] sec_units_r;
   reg [2:0] sec_tens_r;
   reg [7:0] free_count_r;
   reg [3:0] min_units_r;
   reg [2:0] min_tens_r;
   reg [3:0] hour_units_r;
   reg [1:0] hour_tens_r;
   reg [2:0] ctrl_r;
   reg [31:0] tick_cnt_r;
   reg [2:0] busy_cnt_r;
   reg [3:0] aw_addr_r;
   reg aw_held_r;
   reg [31:0] w_data_r;
   reg w_strb0_r;
   reg w_held_r;
   wire fmt24 = ctrl_r[`RTCC_CTRL_FMT24_BIT];
   wire freerun = ctrl_r[`RTCC_CTRL_FREERUN_BIT];
   wire run = ctrl_r[`RTCC_CTRL_RUN_BIT];
   wire tick = run && (tick_cnt_r == TICK_CYCLES - 1);
   wire busy = (busy_cnt_r != 3'h0);
   wire [3:0] sec_units_nxt;
   wire [2:0] sec_tens_nxt;
   wire sec_carry;
   wire [3:0] min_units_nxt;
   wire [2:0] min_tens_nxt;
   wire min_carry;
   wire [3:0] hour_units_nxt;
   wire [2:0] hour_tens_nxt;
   wire hour_carry;
   // top digits of a sixty count
   localparam [3:0] UNITS_TOP = 4'h9;
   localparam [2:0] TENS_TOP_60 = 3'h5;

   // last hour before the wrap; no pm flag is kept in 12-hour mode
   function [6:0] hour_top;
      input fmt24_f;
      begin
         if (fmt24_f) begin
            hour_top = 7'h23;
         end else begin
            hour_top = 7'h11;
         end
      end
   endfunction
   wire [6:0] hour_top_bcd = hour_top(fmt24);
   wire [3:0] hour_top_units = hour_top_bcd[3:0];
   wire [2:0] hour_top_tens = hour_top_bcd[6:4];

   function [7:0] rd_field;
      input busy_f;
      input [6:0] val_f;
      begin
         rd_field = {busy_f, val_f};
      end
   endfunction

   rtcc_bcd_step u_sec_step (
      .units_i(sec_units_r),
      .tens_i(sec_tens_r),
      .top_units_i(UNITS_TOP),
      .top_tens_i(TENS_TOP_60),
      .units_o(sec_units_nxt),
      .tens_o(sec_tens_nxt),
      .carry_o(sec_carry)
   );

   rtcc_bcd_step u_min_step (
      .units_i(min_units_r),
      .tens_i(min_tens_r),
      .top_units_i(UNITS_TOP),
      .top_tens_i(TENS_TOP_60),
      .units_o(min_units_nxt),
      .tens_o(min_tens_nxt),
      .carry_o(min_carry)
   );

   rtcc_bcd_step u_hour_step (
      .units_i(hour_units_r),
      .tens_i({1'b0, hour_tens_r}),
      .top_units_i(hour_top_units),
      .top_tens_i(hour_top_tens),
      .units_o(hour_units_nxt),
      .tens_o(hour_tens_nxt),
      .carry_o(hour_carry)
   );

   // write channel: address and data taken in either order, response after both
   wire aw_take = s_axi_awvalid_i && !aw_held_r && !s_axi_bvalid_o;
   wire w_take = s_axi_wvalid_i && !w_held_r && !s_axi_bvalid_o;
   assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_held_r && !s_axi_bvalid_o;
   wire [3:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_i;
   wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata_i;
   wire wr_strb0 = w_held_r ? w_strb0_r : s_axi_wstrb_i[0];
   wire wr_go = (aw_held_r || aw_take) && (w_held_r || w_take);
   wire wr_en = wr_go && wr_strb0;
   wire wr_mapped = (wr_addr[1:0] == 2'h0);

   // each half is parked until its partner arrives, so the order does not matter
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 4'h0;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end else if (aw_take) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr_i;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0;
         w_strb0_r <= 1'b0;
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end else if (w_take) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata_i;
         w_strb0_r <= s_axi_wstrb_i[0];
      end
   end

   // no write is taken while bvalid stands, so the two branches never meet
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `RTCC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= wr_mapped ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // one-second enable from the divider; it parks at zero while the clock is stopped
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_r <= 32'h0;
      end else if (!run || tick) begin
         tick_cnt_r <= 32'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   // busy spans a short window around each update so a racing read is flagged
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_cnt_r <= 3'h0;
      end else if (run && (tick_cnt_r >= TICK_CYCLES - `RTCC_BUSY_CYCLES)) begin
         busy_cnt_r <= 3'h4;
      end else if (busy) begin
         busy_cnt_r <= busy_cnt_r - 3'h1;
      end
   end

   function reg_hit;
      input [3:0] addr_f;
      input [3:0] off_f;
      begin
         reg_hit = (addr_f == off_f);
      end
   endfunction
   wire wr_hit = wr_en && wr_mapped;
   wire sec_we = wr_hit && reg_hit(wr_addr, `RTCC_OFF_SEC);
   wire min_we = wr_hit && reg_hit(wr_addr, `RTCC_OFF_MIN);
   wire hour_we = wr_hit && reg_hit(wr_addr, `RTCC_OFF_HOUR);
   wire ctrl_we = wr_hit && reg_hit(wr_addr, `RTCC_OFF_CTRL);
   // each field steps only when every field below it has wrapped
   wire sec_adv = tick && !freerun;
   wire min_adv = sec_adv && sec_carry;
   wire hour_adv = min_adv && min_carry;

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_r <= `RTCC_CTRL_RST;
      end else if (ctrl_we) begin
         ctrl_r <= wr_data[2:0];
      end
   end

   // the free count shares the seconds offset, so a seconds write loads it too
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         free_count_r <= 8'h00;
      end else if (sec_we) begin
         free_count_r <= wr_data[7:0];
      end else if (tick && freerun) begin
         free_count_r <= free_count_r + 8'h01;
      end
   end

   // in every field a software write in the same cycle as a tick wins over the tick
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sec_units_r <= 4'h0;
         sec_tens_r <= 3'h0;
      end else if (sec_we) begin
         sec_units_r <= wr_data[3:0];
         sec_tens_r <= wr_data[6:4];
      end else if (sec_adv) begin
         sec_units_r <= sec_units_nxt;
         sec_tens_r <= sec_tens_nxt;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         min_units_r <= 4'h0;
         min_tens_r <= 3'h0;
      end else if (min_we) begin
         min_units_r <= wr_data[3:0];
         min_tens_r <= wr_data[6:4];
      end else if (min_adv) begin
         min_units_r <= min_units_nxt;
         min_tens_r <= min_tens_nxt;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hour_units_r <= 4'h0;
         hour_tens_r <= 2'h0;
      end else if (hour_we) begin
         hour_units_r <= wr_data[3:0];
         hour_tens_r <= wr_data[5:4];
      end else if (hour_adv) begin
         hour_units_r <= hour_units_nxt;
         hour_tens_r <= hour_tens_nxt[1:0];
      end
   end

   // the day carry is a one-cycle pulse for the weekday counter
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         day_carry_o <= 1'b0;
      end else begin
         day_carry_o <= hour_adv && hour_carry;
      end
   end

   // read channel: one cycle from address acceptance to rvalid
   assign s_axi_arready_o = !s_axi_rvalid_o;
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0;
      case (s_axi_araddr_i)
         `RTCC_OFF_SEC: begin
            if (freerun) begin
               rd_mux[7:0] = free_count_r;
            end else begin
               rd_mux[7:0] = rd_field(busy, {sec_tens_r, sec_units_r});
            end
         end
         `RTCC_OFF_MIN: begin
            rd_mux[7:0] = rd_field(busy, {min_tens_r, min_units_r});
         end
         `RTCC_OFF_HOUR: begin
            rd_mux[7:0] = rd_field(busy, {1'b0, hour_tens_r, hour_units_r});
         end
         `RTCC_OFF_CTRL: begin
            rd_mux[2:0] = ctrl_r;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end
   wire rd_mapped = (s_axi_araddr_i[1:0] == 2'h0);
   wire rd_take = s_axi_arvalid_i && s_axi_arready_o;

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_rvalid_o <= 1'b0;
      end else if (rd_take) begin
         s_axi_rvalid_o <= 1'b1;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // read data is loaded only on acceptance so it stands until rready
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_axi_rdata_o <= 32'h0;
         s_axi_rresp_o <= `RTCC_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rdata_o <= rd_mapped ? rd_mux : 32'h0;
         s_axi_rresp_o <= rd_mapped ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
      end
   end
endmodule

// >>> pkg/rtcc_regs.vh
// register offsets, field positions, reset values and timing counts of the time-of-day counters
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH
`define RTCC_OFF_SEC 4'h0
`define RTCC_OFF_MIN 4'h4
`define RTCC_OFF_HOUR 4'h8
`define RTCC_OFF_CTRL 4'hc
`define RTCC_BUSY_BIT 7
`define RTCC_CTRL_FMT24_BIT 0
`define RTCC_CTRL_FREERUN_BIT 1
`define RTCC_CTRL_RUN_BIT 2
`define RTCC_CTRL_RST 3'h0
`define RTCC_CLK_HZ 125000000
`define RTCC_TICK_PERIOD_S 1
`define RTCC_TICK_CYCLES (`RTCC_CLK_HZ * `RTCC_TICK_PERIOD_S)
`define RTCC_BUSY_CYCLES 4
`define RTCC_RESP_OKAY 2'h0
`define RTCC_RESP_SLVERR 2'h2
`endif

// >>> hw/rtcc_bcd_step.v
// one bcd time field: next value after a carry, with wrap and carry out
`timescale 1ns/1ps
module rtcc_bcd_step (
   input wire [3:0] units_i,
   input wire [2:0] tens_i,
   input wire [3:0] top_units_i,
   input wire [2:0] top_tens_i,
   output reg [3:0] units_o,
   output reg [2:0] tens_o,
   output reg carry_o
);
   always @* begin
      units_o = units_i;
      tens_o = tens_i;
      carry_o = 1'b0;
      if ((units_i == top_units_i) && (tens_i == top_tens_i)) begin
         units_o = 4'h0;
         tens_o = 3'h0;
         carry_o = 1'b1;
      end else if (units_i >= 4'h9) begin
         units_o = 4'h0;
         tens_o = tens_i + 3'h1;
      end else begin
         units_o = units_i + 4'h1;
      end
   end
endmodule

// >>> testbench/rtcc_tod_sva.sv
// bus handshake and field range checker for the time-of-day counters
`timescale 1ns/1ps
`include "rtcc_regs.vh"
module rtcc_tod_sva #(
   parameter TICK_CYCLES = `RTCC_TICK_CYCLES
) (
   input wire mclk_i,
   input wire reset_n_i,
   input wire s_axi_awvalid_i,
   input wire s_axi_awready_o,
   input wire s_axi_wvalid_i,
   input wire s_axi_wready_o,
   input wire [1:0] s_axi_bresp_o,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [3:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   input wire s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire [1:0] s_axi_rresp_o,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire day_carry_o
);
   reg [3:0] raddr_r;
   // the read address is gone once taken, so keep it for the answer
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         raddr_r <= 4'h0;
      else if (s_axi_arvalid_i && s_axi_arready_o)
         raddr_r <= s_axi_araddr_i;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_wr_taken;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence s_rd_answer;
      s_axi_rvalid_o ##0 1'b1;
   endsequence
   chk_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid_o)
      else $error("write answer late");
   chk_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write answer dropped");
   chk_aw_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while answering");
   chk_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_rd_answer)
      else $error("read answer late");
   chk_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read answer dropped");
   chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken while answering");
   chk_hour_shape: assert property (s_axi_rvalid_o && raddr_r == `RTCC_OFF_HOUR |-> s_axi_rdata_o[6] == 1'b0 && s_axi_rdata_o[5:4] <= 2'h2)
      else $error("hour field shape wrong");
   chk_min_range: assert property (s_axi_rvalid_o && raddr_r == `RTCC_OFF_MIN |-> s_axi_rdata_o[6:4] <= 3'h5 && s_axi_rdata_o[3:0] <= 4'h9)
      else $error("minute digit out of range");
   chk_unaligned: assert property (s_axi_rvalid_o && raddr_r[1:0] != 2'h0 |-> s_axi_rresp_o == `RTCC_RESP_SLVERR && s_axi_rdata_o == 32'h0)
      else $error("unaligned read not refused");
   chk_day_single: assert property (day_carry_o |=> !day_carry_o)
      else $error("day carry longer than one cycle");
   chk_b_drops: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write answer not retired");
   chk_r_drops: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read answer not retired");
endmodule
bind rtcc_time_of_day rtcc_tod_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
   .mclk_i(mclk_i), .reset_n_i(reset_n_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .day_carry_o(day_carry_o)
);

// >>> testbench/tb_rtc_time_of_day_counters.sv
// self-checking bench for the time-of-day counters over axi4-lite
`timescale 1ns/1ps
`include "rtcc_regs.vh"
module tb_rtc_time_of_day_counters;
   reg mclk_i, reset_n_i;
   reg [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
   reg [31:0] s_axi_wdata_i, rd_data;
   reg s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
   wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   wire day_carry_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   reg [1:0] rd_resp;
   reg [39:0] cases [0:4];
   integer errors, n_tests, i, k, n_day, day_base;
   rtcc_time_of_day #(.TICK_CYCLES(40)) dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
      .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
      .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
      .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
      .s_axi_rready_i(s_axi_rready_i), .day_carry_o(day_carry_o));
   always #4 mclk_i = ~mclk_i;
   // counting the pulses shows a doubled carry as well as a missing one
   always @(posedge mclk_i or negedge reset_n_i)
      if (!reset_n_i) n_day <= 0;
      else if (day_carry_o) n_day <= n_day + 1;
   task check(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task report_and_stop;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   // handshakes are judged at the falling edge, where inputs and answers are settled
   task xfer(input wr, input [3:0] a, input [31:0] d);
      reg ah, wh, rh, done;
      integer n;
   begin
      if (wr) begin
         s_axi_awaddr_i <= a;
         s_axi_wdata_i <= d;
         s_axi_awvalid_i <= 1'b1;
         s_axi_wvalid_i <= 1'b1;
         s_axi_bready_i <= 1'b1;
      end else begin
         s_axi_araddr_i <= a;
         s_axi_arvalid_i <= 1'b1;
         s_axi_rready_i <= 1'b1;
      end
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
         @(negedge mclk_i);
         ah = s_axi_awvalid_i && s_axi_awready_o;
         wh = s_axi_wvalid_i && s_axi_wready_o;
         rh = s_axi_arvalid_i && s_axi_arready_o;
         done = wr ? s_axi_bvalid_o : s_axi_rvalid_o;
         rd_data = s_axi_rdata_o;
         rd_resp = wr ? s_axi_bresp_o : s_axi_rresp_o;
         @(posedge mclk_i);
         if (ah) s_axi_awvalid_i <= 1'b0;
         if (wh) s_axi_wvalid_i <= 1'b0;
         if (rh) s_axi_arvalid_i <= 1'b0;
         if (done) s_axi_bready_i <= 1'b0;
         if (done) s_axi_rready_i <= 1'b0;
      end
      if (!done) begin
         errors = errors + 1;
         report_and_stop;
      end
      @(posedge mclk_i);
   end
   endtask
   // values count only once the busy bit reads clear
   task poll_zero;
   begin
      rd_data = 32'hffff_ffff;
      for (k = 0; k < 300 && rd_data !== 32'h0; k = k + 1)
         xfer(1'b0, `RTCC_OFF_SEC, 32'h0);
      check(rd_data, 32'h0);
      if (rd_data !== 32'h0) report_and_stop;
   end
   endtask
   initial begin
      {mclk_i, reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i} = 4'h0;
      {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 3'h0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 40'h0;
      s_axi_wstrb_i = 4'hf;
      errors = 0;
      n_tests = 0;
      // {control, minutes in, hours in, minutes out, hours out} after one tick from xx:59
      cases[0] = 40'h04_59_11_00_00;
      cases[1] = 40'h04_09_09_10_09;
      cases[2] = 40'h05_59_11_00_12;
      cases[3] = 40'h05_59_19_00_20;
      cases[4] = 40'h05_59_23_00_00;
      repeat (6) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      for (i = 0; i < 16; i = i + 4) begin
         xfer(1'b0, i[3:0], 32'h0);
         check(rd_data, 32'h0);
      end
      for (i = 0; i < 5; i = i + 1) begin
         xfer(1'b1, `RTCC_OFF_SEC, 32'h59);
         xfer(1'b1, `RTCC_OFF_MIN, {24'h0, cases[i][31:24]});
         xfer(1'b1, `RTCC_OFF_HOUR, {24'h0, cases[i][23:16]});
         day_base = n_day;
         xfer(1'b1, `RTCC_OFF_CTRL, {24'h0, cases[i][39:32]});
         poll_zero;
         xfer(1'b1, `RTCC_OFF_CTRL, 32'h0);
         xfer(1'b0, `RTCC_OFF_MIN, 32'h0);
         check(rd_data, {24'h0, cases[i][15:8]});
         xfer(1'b0, `RTCC_OFF_HOUR, 32'h0);
         check(rd_data, {24'h0, cases[i][7:0]});
         check(n_day - day_base, {31'h0, cases[i][7:0] == 8'h00});
      end
      xfer(1'b1, 4'h5, 32'h33);
      check({30'h0, rd_resp}, {30'h0, `RTCC_RESP_SLVERR});
      xfer(1'b0, 4'h9, 32'h0);
      check({30'h0, rd_resp}, {30'h0, `RTCC_RESP_SLVERR});
      xfer(1'b1, `RTCC_OFF_HOUR, 32'h45);
      xfer(1'b0, `RTCC_OFF_HOUR, 32'h0);
      check(rd_data, 32'h05);
      // a write with byte lane 0 off is answered but leaves the register alone
      s_axi_wstrb_i <= 4'h0;
      xfer(1'b1, `RTCC_OFF_HOUR, 32'h11);
      check({30'h0, rd_resp}, {30'h0, `RTCC_RESP_OKAY});
      s_axi_wstrb_i <= 4'hf;
      xfer(1'b0, `RTCC_OFF_HOUR, 32'h0);
      check(rd_data, 32'h05);
      // free count passes 0xff, which no bcd value can
      xfer(1'b1, `RTCC_OFF_SEC, 32'hfe);
      xfer(1'b1, `RTCC_OFF_CTRL, 32'h6);
      poll_zero;
      report_and_stop;
   end
endmodule
